// ==== ctm_defines.vh ====
// register offsets, field positions, encodings and reset values of the compact timer
`ifndef CTM_DEFINES_VH
`define CTM_DEFINES_VH

// apb byte addresses, one aligned word per register
`define CTM_ADDR_W 8
`define CTM_OFS_CTRL0 8'h00
`define CTM_OFS_CTRL1 8'h04
`define CTM_OFS_CNTL 8'h08
`define CTM_OFS_CNTH 8'h0C
`define CTM_OFS_CMPAL 8'h10
`define CTM_OFS_CMPAH 8'h14
`define CTM_OFS_CMPP 8'h18
`define CTM_OFS_STAT 8'h1C

// first control register fields
`define CTM_C0_PAUSE 7
`define CTM_C0_CKSEL_HI 6
`define CTM_C0_CKSEL_LO 4
`define CTM_C0_ON 3
`define CTM_C0_WMASK 8'hF8

// second control register fields
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_FUNC_HI 5
`define CTM_C1_FUNC_LO 4
`define CTM_C1_INIT 3
`define CTM_C1_INV 2
`define CTM_C1_SWAP 1
`define CTM_C1_CLRSEL 0

// operating modes
`define CTM_MODE_CMP 2'h0
`define CTM_MODE_UNDEF 2'h1
`define CTM_MODE_PWM 2'h2
`define CTM_MODE_TMR 2'h3

// output function codes
`define CTM_FN_00 2'h0
`define CTM_FN_01 2'h1
`define CTM_FN_10 2'h2
`define CTM_FN_11 2'h3

// clock source codes
`define CTM_CK_DIV4 3'h0
`define CTM_CK_SYS 3'h1
`define CTM_CK_DIV16 3'h2
`define CTM_CK_DIV64 3'h3
`define CTM_CK_SUB0 3'h4
`define CTM_CK_SUB1 3'h5
`define CTM_CK_EXTR 3'h6
`define CTM_CK_EXTF 3'h7

// status register bits
`define CTM_ST_AFLAG 0
`define CTM_ST_PFLAG 1
`define CTM_ST_PIN 2

// reset values
`define CTM_RST_BYTE 8'h00
`define CTM_RST_WORD 16'h0000

`endif

// ==== ctm_timer.v ====
// compact 16-bit timer: control registers, counter, comparators, output pin, apb slave
// Contract
// - counter-on rising edge zeroes the counter, then it runs.
// - counter-on falling edge stops counting and holds the value.
// - counter-on rising edge returns pin to initial level in compare and pwm; only compare reloads it here, the pwm pin follows function and count.
// - low three bits of first control register read zero.
// - mode 00 compare, 10 pwm, 11 timer, 01 undefined.
// - timer mode leaves pin unused; initial level and invert ignored.
// - compare mode A match: 00 keep, 01 low, 10 high, 11 toggle.
// - pwm function: 00 inactive, 01 active, 10 waveform, 11 undefined.
// - compare match changes pin only if requested level differs.
// - initial level bit: start level in compare, polarity in pwm.
// - invert bit set inverts the output pin.
// - pwm swap 0: P period, A duty; 1: roles exchanged.
// - clear select 1 clears on A match, 0 on P match or overflow.
// - overflow clears only when compare value P is all zero.
// - clear select is ignored in pwm mode.
// - counter read as low and high read-only bytes, reset zero.
// - second control register all read/write, reset zero.
// - high byte read copies low byte into buffer read later.
// - P compares with upper eight counter bits, A with all sixteen.
// - clear select 1 in compare mode raises only the A flag.
//
// Local design decisions: the APB register port and the placing of the registers.
`include "ctm_defines.vh"

module ctm_timer (
   input wire clk,
   input wire srst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire sub_tick,
   input wire timer_clk_in,
   output reg timer_output_pin,
   output reg timer_output_pin_oe,
   output wire compare_a_flag,
   output wire compare_p_flag
);

   localparam [15:0] ONE16 = 16'h0001;
   localparam [5:0] ONE6 = 6'h01;

   reg [7:0] ctrl0_r;
   reg [7:0] ctrl1_r;
   reg [15:0] count_r;
   reg [15:0] cmpa_r;
   reg [7:0] cmpp_r;
   reg [7:0] wbuf_r;
   reg [7:0] rbuf_r;
   reg on_d_r;
   reg [5:0] pre_r;
   reg ext_d_r;
   reg aflag_r;
   reg pflag_r;
   reg lvl_r;

   wire [7:0] addr;
   wire setup;
   wire wr_acc;
   wire hit;
   wire on;
   wire pause;
   wire [2:0] cksel;
   wire [1:0] mode;
   wire [1:0] func;
   wire init_lvl;
   wire invert;
   wire swap;
   wire clr_sel;
   wire on_rise;
   wire is_pwm;
   wire is_cmp;
   wire drives;
   wire [15:0] inc;
   wire a_hit;
   wire p_hit;
   wire do_clr;
   wire [16:0] duty;
   wire pwm_act;
   reg tick;
   reg pwm_lvl;
   reg lvl_nxt;

   // address compare used by both read and write decode
   function sel;
      input [7:0] a;
      input [7:0] ofs;
      begin
         sel = (a == ofs);
      end
   endfunction

   assign addr = paddr[7:0];
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   // mapped only on the eight aligned words
   assign hit = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0)
      && (addr[7:5] == 3'h0);
   // zero wait states; unmapped gives an error in the access phase
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   assign pause = ctrl0_r[`CTM_C0_PAUSE];
   assign cksel = ctrl0_r[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO];
   assign on = ctrl0_r[`CTM_C0_ON];
   assign mode = ctrl1_r[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
   assign func = ctrl1_r[`CTM_C1_FUNC_HI:`CTM_C1_FUNC_LO];
   assign init_lvl = ctrl1_r[`CTM_C1_INIT];
   assign invert = ctrl1_r[`CTM_C1_INV];
   assign swap = ctrl1_r[`CTM_C1_SWAP];
   assign clr_sel = ctrl1_r[`CTM_C1_CLRSEL];
   assign compare_a_flag = aflag_r;
   assign compare_p_flag = pflag_r;

   // mode decode
   // undefined mode 01 behaves as timer mode, pin idle
   assign is_pwm = (mode == `CTM_MODE_PWM);
   assign is_cmp = (mode == `CTM_MODE_CMP);
   assign drives = is_pwm || is_cmp;

   assign on_rise = on && !on_d_r;

   // tick source select; prescaler runs free so source changes need no resync
   always @*
   begin
      case (cksel)
         `CTM_CK_DIV4: tick = (pre_r[1:0] == 2'h3);
         `CTM_CK_SYS: tick = 1'b1;
         `CTM_CK_DIV16: tick = (pre_r[3:0] == 4'hF);
         `CTM_CK_DIV64: tick = (pre_r == 6'h3F);
         `CTM_CK_SUB0: tick = sub_tick;
         `CTM_CK_SUB1: tick = sub_tick;
         `CTM_CK_EXTR: tick = timer_clk_in && !ext_d_r;
         default: tick = !timer_clk_in && ext_d_r;
      endcase
   end

   assign inc = count_r + ONE16;

   // p value zero matches on wrap, i.e. overflow
   assign p_hit = on && !pause && !on_rise && tick && (inc == {cmpp_r, 8'h00});
   // a zero A value never matches: the counter just overflows
   assign a_hit = on && !pause && !on_rise && tick && (cmpa_r != `CTM_RST_WORD) && (inc == cmpa_r);

   // pwm ignores clear select, swap picks the period comparator
   assign do_clr = is_pwm ? (swap ? a_hit : p_hit) : (clr_sel ? a_hit : p_hit);

   // duty role, p duty of zero means a full 65536 count
   assign duty = swap ? ((cmpp_r == 8'h00) ? 17'h10000 : {1'b0, cmpp_r, 8'h00}) : {1'b0, cmpa_r};
   // duty at or above period gives 100 percent
   assign pwm_act = ({1'b0, count_r} < duty);

   // polarity: active level equals the initial level bit
   always @*
   begin
      case (func)
         `CTM_FN_00: pwm_lvl = !init_lvl;
         `CTM_FN_01: pwm_lvl = init_lvl;
         `CTM_FN_10: pwm_lvl = pwm_act ? init_lvl : !init_lvl;
         default: pwm_lvl = !init_lvl;
      endcase
   end

   // compare-mode level; requesting the present level leaves the pin alone
   always @*
   begin
      lvl_nxt = lvl_r;
      if (on_rise)
      begin
         lvl_nxt = init_lvl;
      end
      // no change when requested level equals current
      else if (is_cmp && a_hit)
      begin
         case (func)
            `CTM_FN_01: lvl_nxt = 1'b0;
            `CTM_FN_10: lvl_nxt = 1'b1;
            `CTM_FN_11: lvl_nxt = !lvl_r;
            default: lvl_nxt = lvl_r;
         endcase
      end
   end

   // prescaler and edge history
   always @(posedge clk)
   begin
      if (srst)
      begin
         pre_r <= 6'h00;
         ext_d_r <= 1'b0;
         on_d_r <= 1'b0;
      end
      else
      begin
         pre_r <= pre_r + ONE6;
         ext_d_r <= timer_clk_in;
         on_d_r <= on;
      end
   end

   // counter
   always @(posedge clk)
   begin
      if (srst)
      begin
         count_r <= `CTM_RST_WORD;
      end
      else if (on_rise)
      begin
         count_r <= `CTM_RST_WORD;
      end
      else if (on && !pause && tick)
      begin
         count_r <= do_clr ? `CTM_RST_WORD : inc;
      end
   end

   // match flags, sticky; write one to clear, a new match wins over the clear
   always @(posedge clk)
   begin
      if (srst)
      begin
         aflag_r <= 1'b0;
         pflag_r <= 1'b0;
      end
      else
      begin
         if (a_hit)
         begin
            aflag_r <= 1'b1;
         end
         else if (wr_acc && hit && sel(addr, `CTM_OFS_STAT) && pwdata[`CTM_ST_AFLAG])
         begin
            aflag_r <= 1'b0;
         end
         // no p flag when A clears in compare or timer mode
         if (p_hit && !(!is_pwm && clr_sel))
         begin
            pflag_r <= 1'b1;
         end
         else if (wr_acc && hit && sel(addr, `CTM_OFS_STAT) && pwdata[`CTM_ST_PFLAG])
         begin
            pflag_r <= 1'b0;
         end
      end
   end

   // output pin, registered
   always @(posedge clk)
   begin
      if (srst)
      begin
         lvl_r <= 1'b0;
         timer_output_pin <= 1'b0;
         timer_output_pin_oe <= 1'b0;
      end
      else
      begin
         lvl_r <= lvl_nxt;
         timer_output_pin_oe <= drives;
         // timer mode pin unused and held low
         if (!drives)
         begin
            timer_output_pin <= 1'b0;
         end
         else if (is_pwm)
         begin
            timer_output_pin <= pwm_lvl ^ invert;
         end
         else
         begin
            timer_output_pin <= lvl_nxt ^ invert;
         end
      end
   end

   // register writes take effect at the access edge
   always @(posedge clk)
   begin
      if (srst)
      begin
         ctrl0_r <= `CTM_RST_BYTE;
         ctrl1_r <= `CTM_RST_BYTE;
         cmpa_r <= `CTM_RST_WORD;
         cmpp_r <= `CTM_RST_BYTE;
         wbuf_r <= `CTM_RST_BYTE;
      end
      else if (wr_acc && hit)
      begin
         if (sel(addr, `CTM_OFS_CTRL0))
         begin
            ctrl0_r <= pwdata[7:0] & `CTM_C0_WMASK;
         end
         else if (sel(addr, `CTM_OFS_CTRL1))
         begin
            ctrl1_r <= pwdata[7:0];
         end
         else if (sel(addr, `CTM_OFS_CMPAL))
         begin
            // low byte waits in the buffer so both bytes land together
            wbuf_r <= pwdata[7:0];
         end
         else if (sel(addr, `CTM_OFS_CMPAH))
         begin
            cmpa_r <= {pwdata[7:0], wbuf_r};
         end
         else if (sel(addr, `CTM_OFS_CMPP))
         begin
            cmpp_r <= pwdata[7:0];
         end
      end
   end

   // read data sampled in the setup cycle, so it is ready in the access phase
   always @(posedge clk)
   begin
      if (srst)
      begin
         prdata <= 32'h00000000;
         rbuf_r <= `CTM_RST_BYTE;
      end
      else if (setup && !pwrite)
      begin
         prdata <= 32'h00000000;
         if (!hit)
         begin
            prdata <= 32'h00000000;
         end
         else if (sel(addr, `CTM_OFS_CTRL0))
         begin
            prdata[7:0] <= ctrl0_r & `CTM_C0_WMASK;
         end
         else if (sel(addr, `CTM_OFS_CTRL1))
         begin
            prdata[7:0] <= ctrl1_r;
         end
         else if (sel(addr, `CTM_OFS_CNTL))
         begin
            // low byte comes from the buffer
            prdata[7:0] <= rbuf_r;
         end
         else if (sel(addr, `CTM_OFS_CNTH))
         begin
            prdata[7:0] <= count_r[15:8];
            rbuf_r <= count_r[7:0];
         end
         else if (sel(addr, `CTM_OFS_CMPAL))
         begin
            prdata[7:0] <= rbuf_r;
         end
         else if (sel(addr, `CTM_OFS_CMPAH))
         begin
            prdata[7:0] <= cmpa_r[15:8];
            rbuf_r <= cmpa_r[7:0];
         end
         else if (sel(addr, `CTM_OFS_CMPP))
         begin
            prdata[7:0] <= cmpp_r;
         end
         else
         begin
            prdata[2:0] <= {timer_output_pin, pflag_r, aflag_r};
         end
      end
   end

endmodule // ctm_timer

// ==== ctm_timer_assertions.sv ====
// port-level assertions for the compact timer
module ctm_timer_assertions (
   input wire clk,
   input wire srst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire timer_output_pin,
   input wire timer_output_pin_oe,
   input wire compare_a_flag,
   input wire compare_p_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (srst);
   reg [7:0] c1_r;
   reg [7:0] c1_d;
   reg on_r;
   reg [1:0] quiet_r;
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire on_rise = wr && paddr == 32'h0 && pwdata[3] && !on_r;
   // shadow control bits; quiet counts idle cycles while off, so late pin updates settle first
   always @(posedge clk)
   begin
      if (srst)
      begin
         c1_r <= 8'h00;
         on_r <= 1'b0;
         quiet_r <= 2'h0;
      end
      else
      begin
         if (wr && paddr == 32'h4)
            c1_r <= pwdata[7:0];
         if (wr && paddr == 32'h0)
            on_r <= pwdata[3];
         quiet_r <= (wr || on_r) ? 2'h0 : ((quiet_r == 2'h3) ? 2'h3 : quiet_r + 2'h1);
      end
      c1_d <= c1_r;
   end
   ready_zero_wait_a: assert property (acc |-> pready) else $error("pready low in access");
   read_upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
   unmapped_error_a: assert property (acc |-> pslverr == (paddr > 32'h1C || paddr[1:0] != 2'h0))
      else $error("error response wrong");
   ctrl_low_zero_a: assert property (acc && !pwrite && paddr == 32'h0 |-> prdata[2:0] == 3'h0)
      else $error("low control bits not zero");
   reset_clears_a: assert property ($past(srst) |-> !timer_output_pin_oe && !compare_a_flag && !compare_p_flag)
      else $error("state not cleared by reset");
   off_holds_a: assert property (quiet_r == 2'h3 |-> $stable(timer_output_pin) && $stable(compare_a_flag))
      else $error("activity while timer off");
   start_level_a: assert property (on_rise && c1_r[7:6] == 2'h0 |-> ##2 timer_output_pin == (c1_r[3] ^ c1_r[2]))
      else $error("pin not at initial level");
   pwm_forced_a: assert property (c1_r == c1_d && c1_r[7:5] == 3'h4 |-> timer_output_pin == (c1_r[3] ^ c1_r[2] ^ !c1_r[4]))
      else $error("forced pwm level wrong");
   p_flag_quiet_a: assert property (c1_r == c1_d && c1_r[7:6] == 2'h0 && c1_r[0] |-> !$rose(compare_p_flag))
      else $error("p flag raised with a clearing");
   timer_idle_a: assert property (c1_r == c1_d && c1_r[7:6] == 2'h3 |-> !timer_output_pin_oe)
      else $error("pin driven in timer mode");
   cover property (on_rise);
   cover property ($rose(compare_a_flag));
   cover property (acc && pslverr);
endmodule // ctm_timer_assertions

bind ctm_timer ctm_timer_assertions u_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_output_pin(timer_output_pin), .timer_output_pin_oe(timer_output_pin_oe),
   .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag));

// ==== tb.sv ====
// self-checking bench for the compact timer over apb
`include "ctm_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, pin, oe, fa, fp;
   int fail_count = 0;
   int check_count = 0;
   logic [31:0] rv;
   logic er;
   logic [15:0] v1, v2;
   logic [7:0] c1;
   logic [2:0] ex;
   logic [7:0] ra [4] = '{`CTM_OFS_CTRL0, `CTM_OFS_CTRL1, `CTM_OFS_CNTL, `CTM_OFS_CNTH};
   // enable, pin after match, pin at start, second control value
   logic [10:0] cases [15] = '{11'h400, 11'h410, 11'h620, 11'h630, 11'h518, 11'h728, 11'h524, 11'h621,
      11'h799, 11'h490, 11'h488, 11'h780, 11'h0C1, 11'h6A0, 11'h4A2};

   ctm_timer uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sub_tick(1'b0),
      .timer_clk_in(1'b0), .timer_output_pin(pin), .timer_output_pin_oe(oe), .compare_a_flag(fa),
      .compare_p_flag(fp));

   always #12.5 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      // no wait count assumed; only the watchdog ends a hang
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // high byte first so the low byte comes from the latched copy
   task automatic rd16(output logic [15:0] v);
      xfer(1'b0, `CTM_OFS_CNTH, 8'h00);
      v[15:8] = rv[7:0];
      xfer(1'b0, `CTM_OFS_CNTL, 8'h00);
      v[7:0] = rv[7:0];
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      foreach (ra[i])
      begin
         xfer(1'b0, ra[i], 8'h00);
         chk("reset value", rv, 32'h0);
      end
      xfer(1'b1, `CTM_OFS_CTRL1, 8'hA5);
      xfer(1'b0, `CTM_OFS_CTRL1, 8'h00);
      chk("second control", rv, 32'hA5);
      xfer(1'b1, `CTM_OFS_CTRL0, 8'hFF);
      xfer(1'b0, `CTM_OFS_CTRL0, 8'h00);
      chk("first control", rv, 32'hF8);
      xfer(1'b0, 8'h20, 8'h00);
      chk("unmapped error", er, 1'b1);
      xfer(1'b1, `CTM_OFS_CTRL0, 8'h10);
      xfer(1'b1, `CTM_OFS_CMPAL, 8'h10);
      xfer(1'b1, `CTM_OFS_CMPAH, 8'h00);
      // each defined mode and output function, timer stopped before each change
      foreach (cases[i])
      begin
         {ex, c1} = cases[i];
         xfer(1'b1, `CTM_OFS_CTRL0, 8'h10);
         xfer(1'b1, `CTM_OFS_STAT, 8'h03);
         xfer(1'b1, `CTM_OFS_CTRL1, c1);
         xfer(1'b1, `CTM_OFS_CTRL0, 8'h18);
         repeat (3) @(posedge clk);
         chk("pin at start", pin, ex[0]);
         repeat (40) @(posedge clk);
         chk("pin after match", pin, ex[1]);
         chk("output enable", oe, ex[2]);
         chk("compare a flag", fa, 1'b1);
         chk("compare p flag", fp, 1'b0);
         rd16(v1);
         chk("counter cleared", v1 < 16'h0011, (c1[7:6] == 2'h2) ? c1[1] : c1[0]);
      end
      xfer(1'b1, `CTM_OFS_CTRL0, 8'h10);
      xfer(1'b1, `CTM_OFS_CTRL1, 8'h00);
      xfer(1'b1, `CTM_OFS_CTRL0, 8'h18);
      repeat (100) @(posedge clk);
      xfer(1'b1, `CTM_OFS_CTRL0, 8'h10);
      rd16(v1);
      repeat (20) @(posedge clk);
      rd16(v2);
      chk("count held", v2, v1);
      chk("count ran", v1 > 16'h0050, 1'b1);
      xfer(1'b1, `CTM_OFS_CTRL0, 8'h18);
      xfer(1'b1, `CTM_OFS_CTRL0, 8'h10);
      rd16(v2);
      chk("count restarted", v2 < 16'h0010, 1'b1);
      // comparator P on the upper count byte clears the counter and sets its flag
      xfer(1'b1, `CTM_OFS_CMPP, 8'h01);
      xfer(1'b1, `CTM_OFS_STAT, 8'h03);
      xfer(1'b1, `CTM_OFS_CTRL0, 8'h18);
      repeat (300) @(posedge clk);
      chk("p flag at upper byte", fp, 1'b1);
      rd16(v1);
      chk("p clears counter", v1 < 16'h0100, 1'b1);
      xfer(1'b0, `CTM_OFS_STAT, 8'h00);
      chk("status flags", rv, 32'h3);
      // A clearing beyond the P value: P matches but must not flag
      xfer(1'b1, `CTM_OFS_CTRL0, 8'h10);
      xfer(1'b1, `CTM_OFS_CMPAL, 8'h00);
      xfer(1'b1, `CTM_OFS_CMPAH, 8'h02);
      xfer(1'b1, `CTM_OFS_CTRL1, 8'h01);
      xfer(1'b1, `CTM_OFS_STAT, 8'h03);
      xfer(1'b1, `CTM_OFS_CTRL0, 8'h18);
      repeat (300) @(posedge clk);
      chk("p flag with a clearing", fp, 1'b0);
      chk("a flag before match", fa, 1'b0);
      repeat (300) @(posedge clk);
      chk("a flag after match", fa, 1'b1);
      rd16(v1);
      chk("a clears counter", v1 < 16'h0100, 1'b1);
      summarize;
   end

   // cuts a hang short
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      summarize;
   end
endmodule // tb
